// ===== design/tss_pkg.sv
// shared constants, field layout and types of the touch scan sequencer
package tss_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  // register offsets
  localparam logic [7:0] OFS_X_RESULT   = 8'h00;
  localparam logic [7:0] OFS_Y_RESULT   = 8'h01;
  localparam logic [7:0] OFS_Z1_RESULT  = 8'h02;
  localparam logic [7:0] OFS_Z2_RESULT  = 8'h03;
  localparam logic [7:0] OFS_KEYPAD     = 8'h04;
  localparam logic [7:0] OFS_DAC        = 8'h0B;
  localparam logic [7:0] OFS_CTRL       = 8'h20;
  localparam logic [7:0] OFS_STATUS     = 8'h21;
  // reset values
  localparam logic [15:0] RST_RESULT    = 16'h0000;
  localparam logic [15:0] RST_DAC       = 16'h0080;
  localparam logic [15:0] RST_CTRL      = 16'h0000;
  // control register fields: lsb positions
  localparam int CTRL_MODE_LSB   = 14;
  localparam int CTRL_FUNC_LSB   = 8;
  localparam int CTRL_AVG_LSB    = 4;
  localparam int CTRL_SETTLE_LSB = 0;
  // result slot indices, equal to the low offset bits
  localparam logic [1:0] IDX_X  = 2'h0;
  localparam logic [1:0] IDX_Y  = 2'h1;
  localparam logic [1:0] IDX_Z1 = 2'h2;
  localparam logic [1:0] IDX_Z2 = 2'h3;
  // result width and dac width
  localparam int RES_BITS = 12;
  localparam int DAC_BITS = 8;
  // fixed sequence overheads and per-conversion gap in ns
  localparam int OVH_XY_NS   = 2500;
  localparam int OVH_XYZ_NS  = 4750;
  localparam int OVH_ONE_NS  = 1250;
  localparam int GAP_NS      = 4400;
  localparam int PRE_SNS_NS  = 1000;
  localparam int SETTLE0_NS  = 500;
  localparam int SETTLE1_NS  = 5000;
  localparam int SETTLE2_NS  = 10000;
  localparam int SETTLE3_NS  = 40000;
  // least times round up to whole cycles
  localparam int OVH_XY_CYC  = (OVH_XY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVH_XYZ_CYC = (OVH_XYZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVH_ONE_CYC = (OVH_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC     = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE0_CYC = (SETTLE0_NS + PRE_SNS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE1_CYC = (SETTLE1_NS + PRE_SNS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE2_CYC = (SETTLE2_NS + PRE_SNS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE3_CYC = (SETTLE3_NS + PRE_SNS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // control modes
  typedef enum logic [1:0] {MODE_SELF, MODE_HOST_INIT, MODE_HOST_CTRL, MODE_SPARE} tss_mode_t;
  // function codes written to the control register
  localparam logic [3:0] FN_NONE   = 4'h0;
  localparam logic [3:0] FN_XY     = 4'h1;
  localparam logic [3:0] FN_XYZ    = 4'h2;
  localparam logic [3:0] FN_X      = 4'h3;
  localparam logic [3:0] FN_Y      = 4'h4;
  localparam logic [3:0] FN_Z      = 4'h5;
  localparam logic [3:0] FN_DRV_X  = 4'h6;
  localparam logic [3:0] FN_DRV_Y  = 4'h7;
  localparam logic [3:0] FN_DRV_Z  = 4'h8;
  localparam logic [3:0] FN_CONV_X = 4'h9;
  localparam logic [3:0] FN_CONV_Y = 4'hA;
  localparam logic [3:0] FN_CONV_Z = 4'hB;
  localparam logic [3:0] FN_STOP   = 4'hC;
  // sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_OVH, ST_SETTLE, ST_CONV, ST_WAIT, ST_GAP,
                            ST_STORE} tss_state_t;
endpackage

// ===== design/tss_avg_acc.sv
// accumulator that averages a power-of-two number of converter samples
`timescale 1ns/1ps
module tss_avg_acc #(
  parameter int W = 12
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         clear,
  input  wire logic         sample_valid,
  input  wire logic [W-1:0] sample,
  input  wire logic [2:0]   shift,
  output logic      [W-1:0] mean
);
  logic [W+4:0] sum;
  logic [W+4:0] next_sum;
  logic [W+4:0] shifted;

  // next sum: clear wins, else add the new sample
  always_comb begin
    next_sum = sum;
    if (clear) begin
      next_sum = '0;
    end else if (sample_valid) begin
      next_sum = sum + {5'h00, sample};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sum <= '0;
    end else begin
      sum <= next_sum;
    end
  end

  // divide by the sample count
  assign shifted = sum >> shift;
  assign mean    = shifted[W-1:0];
endmodule

// ===== design/tss_result_mem.sv
// small result store with one write port and a registered read port
`timescale 1ns/1ps
module tss_result_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [W-1:0]  rd_data
);
  import tss_pkg::*;
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [W-1:0] next_rd_data;

  // next contents and read word
  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem[wr_idx] = wr_data;
    end
    next_rd_data = mem[rd_idx];
  end

  // all slots clear to zero on reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= RST_RESULT;
      end
      rd_data <= RST_RESULT;
    end else begin
      mem     <= next_mem;
      rd_data <= next_rd_data;
    end
  end
endmodule

// ===== design/tss_top.sv
// touch scan sequencer: panel drive, timed conversions, averaging, result registers
`timescale 1ns/1ps
module tss_top #(
  parameter int RES_W = tss_pkg::RES_BITS
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             pen_down,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  output logic      [15:0]      reg_rdata,
  input  wire logic             key_scan_valid,
  input  wire logic [15:0]      key_scan_bits,
  input  wire logic             adc_done,
  input  wire logic [RES_W-1:0] adc_data,
  output logic                  adc_start,
  output logic                  adc_power,
  output logic                  conv_clk_en,
  output logic                  x_drive_en,
  output logic                  y_drive_en,
  output logic                  z_drive_en,
  output logic                  pen_touch_irq_n,
  output logic                  result_ready_n,
  output logic      [7:0]       dac_code
);
  import tss_pkg::*;

  tss_state_t   state, next_state;
  logic [15:0]  cnt, next_cnt;
  logic [1:0]   coord, next_coord;
  logic [4:0]   nconv, next_nconv;
  logic         plan_x, next_plan_x;
  logic         plan_z, next_plan_z;
  logic         single, next_single;
  logic         cont, next_cont;
  logic         armed, next_armed;
  logic [2:0]   drv, next_drv;
  logic [15:0]  ctrl, next_ctrl;
  logic [15:0]  keypad, next_keypad;
  logic [7:0]   dac, next_dac;
  logic [4:0]   pend, next_pend;
  logic [15:0]  other_q, next_other_q;
  logic         rd_mem_q, next_rd_mem_q;
  logic         next_irq_n, next_clk_en, next_adc_power;
  logic         ctrl_wr, store_en;
  tss_mode_t    mode;
  logic [3:0]   func;
  logic [2:0]   avg_shift;
  logic [4:0]   avg_n;
  logic [15:0]  settle_cyc;
  logic [RES_W-1:0] mean;
  logic [15:0]  mem_rdata;
  logic         acc_clear;

  // control register fields
  assign mode    = tss_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
  assign func    = reg_wdata[CTRL_FUNC_LSB +: 4];
  assign ctrl_wr = reg_wr && (reg_addr == OFS_CTRL);

  // averaging count and programmed settle time
  always_comb begin
    unique case (ctrl[CTRL_AVG_LSB +: 2])
      2'h0: avg_shift = 3'h0;
      2'h1: avg_shift = 3'h2;
      2'h2: avg_shift = 3'h3;
      2'h3: avg_shift = 3'h4;
    endcase
    avg_n = 5'(1 << avg_shift);
    unique case (ctrl[CTRL_SETTLE_LSB +: 2])
      2'h0: settle_cyc = 16'(SETTLE0_CYC);
      2'h1: settle_cyc = 16'(SETTLE1_CYC);
      2'h2: settle_cyc = 16'(SETTLE2_CYC);
      2'h3: settle_cyc = 16'(SETTLE3_CYC);
    endcase
  end

  // sequencer next state
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_coord  = coord;
    next_nconv  = nconv;
    next_plan_x = plan_x;
    next_plan_z = plan_z;
    next_single = single;
    next_cont   = cont;
    next_armed  = armed;
    next_drv    = drv;
    adc_start   = 1'b0;
    store_en    = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_nconv = 5'h00;
        if (ctrl_wr) begin
          next_armed = 1'b1;
          if (tss_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]) == MODE_HOST_CTRL) begin
            // every drive and conversion needs its own command, except that one Z conversion command takes both Z1 and Z2
            unique case (func)
              FN_DRV_X:  next_drv = 3'b001;
              FN_DRV_Y:  next_drv = 3'b010;
              FN_DRV_Z:  next_drv = 3'b100;
              FN_CONV_X: begin
                next_coord = IDX_X;
                next_state = ST_CONV;
              end
              FN_CONV_Y: begin
                next_coord = IDX_Y;
                next_state = ST_CONV;
              end
              FN_CONV_Z: begin
                next_coord = IDX_Z1;
                next_state = ST_CONV;
              end
              FN_STOP:   next_drv = 3'b000;
              default:   next_drv = drv;
            endcase
          end else begin
            next_drv    = 3'b000;
            next_single = (func == FN_X) || (func == FN_Y) || (func == FN_Z);
            next_cont   = (func == FN_XY) || (func == FN_XYZ);
            next_plan_x = (func == FN_XY) || (func == FN_XYZ);
            next_plan_z = (func == FN_XYZ);
            next_coord  = (func == FN_X) ? IDX_X : (func == FN_Z) ? IDX_Z1 : IDX_Y;
            if (func == FN_XY) begin
              next_cnt = 16'(OVH_XY_CYC);
            end else if (func == FN_XYZ) begin
              next_cnt = 16'(OVH_XYZ_CYC);
            end else begin
              next_cnt = 16'(OVH_ONE_CYC);
            end
            if (tss_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]) == MODE_HOST_INIT &&
                func != FN_NONE && func != FN_STOP && pen_down) begin
              next_state = ST_OVH;
            end
          end
        end else if (pen_down && armed && mode == MODE_SELF) begin
          // touch alone starts a full coordinate scan
          next_single = 1'b0;
          next_plan_x = 1'b1;
          next_plan_z = ctrl[CTRL_FUNC_LSB +: 4] == FN_XYZ;
          next_coord  = IDX_Y;
          next_cnt    = (ctrl[CTRL_FUNC_LSB +: 4] == FN_XYZ) ? 16'(OVH_XYZ_CYC) :
                        16'(OVH_XY_CYC);
          next_state  = ST_OVH;
        end else if (pen_down && cont && mode == MODE_HOST_INIT) begin
          next_coord = IDX_Y;
          next_cnt   = plan_z ? 16'(OVH_XYZ_CYC) : 16'(OVH_XY_CYC);
          next_state = ST_OVH;
        end
      end
      ST_OVH: begin
        if (cnt <= 16'h0001) begin
          next_cnt   = settle_cyc;
          next_state = ST_SETTLE;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
        next_drv = (coord == IDX_X) ? 3'b001 : (coord == IDX_Y) ? 3'b010 : 3'b100;
      end
      ST_SETTLE: begin
        // drivers on, wait programmed settle plus precharge and sense
        next_drv = (coord == IDX_X) ? 3'b001 : (coord == IDX_Y) ? 3'b010 : 3'b100;
        if (cnt <= 16'h0001) begin
          next_state = ST_CONV;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      ST_CONV: begin
        adc_start  = 1'b1;
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (adc_done) begin
          next_nconv = nconv + 5'h01;
          next_cnt   = 16'(GAP_CYC);
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cnt <= 16'h0001) begin
          next_state = (nconv == avg_n) ? ST_STORE : ST_CONV;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      ST_STORE: begin
        store_en   = 1'b1;
        next_nconv = 5'h00;
        next_state = ST_IDLE;
        if (coord == IDX_Z1) begin
          // second pressure value uses the same drive
          next_coord = IDX_Z2;
          next_state = ST_CONV;
        end else if (mode == MODE_HOST_CTRL || single) begin
          next_state = ST_IDLE;
        end else if (coord == IDX_Y && plan_x) begin
          if (pen_down) begin
            next_coord = IDX_X;
            next_cnt   = settle_cyc;
            next_state = ST_SETTLE;
          end else begin
            next_drv = 3'b000;
          end
        end else if (coord == IDX_X && plan_z) begin
          if (pen_down) begin
            next_coord = IDX_Z1;
            next_cnt   = settle_cyc;
            next_state = ST_SETTLE;
          end else begin
            next_drv = 3'b000;
          end
        end else begin
          next_drv = 3'b000;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (ctrl_wr && func == FN_STOP) begin
      next_cont = 1'b0;
    end
  end

  // host-controlled and single-conversion drivers stay on; scans release them when idle
  assign acc_clear      = (state == ST_IDLE) || (state == ST_SETTLE) || (state == ST_STORE);
  assign next_clk_en    = (next_state != ST_IDLE);
  assign next_adc_power = (next_state == ST_CONV) || (next_state == ST_WAIT) ||
                          (next_state == ST_GAP);
  assign next_irq_n     = ~pen_down;

  // register file writes, data-ready bookkeeping, registered read word
  always_comb begin
    next_ctrl     = ctrl;
    next_dac      = dac;
    next_keypad   = keypad;
    next_pend     = pend;
    next_other_q  = other_q;
    next_rd_mem_q = rd_mem_q;
    if (ctrl_wr) begin
      next_ctrl = reg_wdata;
    end
    if (reg_wr && reg_addr == OFS_DAC) begin
      next_dac = reg_wdata[DAC_BITS-1:0];
    end
    // a read clears its pending bit; a new result in the same cycle wins
    if (reg_rd && reg_addr[7:2] == 6'h00) begin
      next_pend[reg_addr[1:0]] = 1'b0;
    end
    if (reg_rd && reg_addr == OFS_KEYPAD) begin
      next_pend[4] = 1'b0;
    end
    if (store_en) begin
      next_pend[coord] = 1'b1;
    end
    if (key_scan_valid) begin
      next_keypad  = key_scan_bits;
      next_pend[4] = 1'b1;
    end
    if (reg_rd) begin
      next_rd_mem_q = (reg_addr[7:2] == 6'h00);
      unique case (reg_addr)
        OFS_KEYPAD: next_other_q = keypad;
        OFS_DAC:    next_other_q = {8'h00, dac};
        OFS_CTRL:   next_other_q = ctrl;
        OFS_STATUS: next_other_q = {result_ready_n, ~pen_touch_irq_n, conv_clk_en, 5'h00,
                                    3'h0, pend};
        default:    next_other_q = 16'h0000;
      endcase
    end
  end

  // result ready goes low while any unread result or key scan exists
  assign reg_rdata = rd_mem_q ? mem_rdata : other_q;
  assign dac_code  = dac;
  assign x_drive_en = drv[0];
  assign y_drive_en = drv[1];
  assign z_drive_en = drv[2];

  // state registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state           <= ST_IDLE;
      cnt             <= 16'h0000;
      coord           <= IDX_Y;
      nconv           <= 5'h00;
      plan_x          <= 1'b0;
      plan_z          <= 1'b0;
      single          <= 1'b0;
      cont            <= 1'b0;
      armed           <= 1'b0;
      drv             <= 3'b000;
      ctrl            <= RST_CTRL;
      keypad          <= RST_RESULT;
      dac             <= RST_DAC[DAC_BITS-1:0];
      pend            <= 5'h00;
      other_q         <= 16'h0000;
      rd_mem_q        <= 1'b0;
      pen_touch_irq_n <= 1'b1;
      conv_clk_en     <= 1'b0;
      adc_power       <= 1'b0;
      result_ready_n  <= 1'b1;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      coord           <= next_coord;
      nconv           <= next_nconv;
      plan_x          <= next_plan_x;
      plan_z          <= next_plan_z;
      single          <= next_single;
      cont            <= next_cont;
      armed           <= next_armed;
      drv             <= next_drv;
      ctrl            <= next_ctrl;
      keypad          <= next_keypad;
      dac             <= next_dac;
      pend            <= next_pend;
      other_q         <= next_other_q;
      rd_mem_q        <= next_rd_mem_q;
      pen_touch_irq_n <= next_irq_n;
      conv_clk_en     <= next_clk_en;
      adc_power       <= next_adc_power;
      result_ready_n  <= ~|next_pend;
    end
  end

  // averaging of converter samples
  tss_avg_acc #(.W(RES_W)) u_avg (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .clear        (acc_clear),
    .sample_valid (state == ST_WAIT && adc_done),
    .sample       (adc_data),
    .shift        (avg_shift),
    .mean         (mean)
  );

  // result slots, right-justified with zero upper bits
  tss_result_mem #(.W(16), .DEPTH(4), .AW(2)) u_mem (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr_en    (store_en),
    .wr_idx   (coord),
    .wr_data  ({(16 - RES_W)'(0), mean}),
    .rd_idx   (reg_addr[1:0]),
    .rd_data  (mem_rdata)
  );
endmodule

// ===== testbench/tss_top_chk.sv
// port checker for the touch scan sequencer, bound to its top module
`timescale 1ns/1ps
module tss_top_chk (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        pen_down,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        key_scan_valid,
  input wire logic        adc_start,
  input wire logic        conv_clk_en,
  input wire logic        x_drive_en,
  input wire logic        y_drive_en,
  input wire logic        z_drive_en,
  input wire logic        pen_touch_irq_n,
  input wire logic        result_ready_n,
  input wire logic [7:0]  dac_code
);
  import tss_pkg::*;
  localparam int SETTLE_MIN = 147;
  logic [2:0]  drv_q;
  logic [2:0]  next_drv_q;
  logic [15:0] drv_cnt;
  logic [15:0] next_drv_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // cycles since the panel driver set last changed, saturating
  always_comb begin
    next_drv_q   = {x_drive_en, y_drive_en, z_drive_en};
    next_drv_cnt = drv_cnt + 16'h0001;
    if (next_drv_q != drv_q) begin
      next_drv_cnt = 16'h0000;
    end else if (drv_cnt == 16'hFFFF) begin
      next_drv_cnt = drv_cnt;
    end
  end
  always_ff @(posedge core_clk) begin
    drv_q   <= next_drv_q;
    drv_cnt <= sys_rst ? 16'h0000 : next_drv_cnt;
  end
  // port relations
  AST_IRQ_ON_TOUCH:
    assert property (pen_down |=> !pen_touch_irq_n) else $error("pen irq not low on touch");
  AST_IRQ_ON_RELEASE:
    assert property ($fell(pen_down) |=> pen_touch_irq_n) else $error("pen irq not released");
  AST_START_CLOCKED:
    assert property (adc_start |-> conv_clk_en) else $error("start without clock");
  AST_DRV_ONEHOT:
    assert property ($onehot0({x_drive_en, y_drive_en, z_drive_en})) else $error("drivers overlap");
  AST_START_PULSE:
    assert property (adc_start |=> !adc_start) else $error("start longer than one cycle");
  AST_START_SETTLED:
    assert property (adc_start |-> $onehot({x_drive_en, y_drive_en, z_drive_en})
      && drv_cnt >= SETTLE_MIN) else $error("start before panel settled");
  AST_RESULT_JUSTIFIED:
    assert property (reg_rd && reg_addr <= OFS_Z2_RESULT |=> reg_rdata[15:12] == 4'h0)
      else $error("result upper bits set");
  AST_DAC_READBACK:
    assert property (reg_rd && !reg_wr && reg_addr == OFS_DAC |=> reg_rdata == {8'h00, dac_code})
      else $error("dac readback wrong");
  AST_DAC_WRITE:
    assert property (reg_wr && reg_addr == OFS_DAC |-> ##2
      {8'h00, dac_code} == ($past(reg_wdata, 2) & 16'h00FF)) else $error("dac code not written");
  AST_KEY_READY:
    assert property (key_scan_valid |-> ##[1:2] !result_ready_n) else $error("ready not low");
endmodule
bind tss_top tss_top_chk u_chk (
  .core_clk, .sys_rst, .pen_down, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .key_scan_valid, .adc_start, .conv_clk_en, .x_drive_en, .y_drive_en, .z_drive_en,
  .pen_touch_irq_n, .result_ready_n, .dac_code
);

// ===== testbench/tss_adc_model.sv
// converter model: answers each start pulse with one sample after a fixed latency
`timescale 1ns/1ps
module tss_adc_model #(
  parameter int LAT = 20
) (
  input  wire logic        core_clk,
  input  wire logic        adc_start,
  input  wire logic [11:0] sample,
  output logic             adc_done,
  output logic      [11:0] adc_data
);
  int          cnt;
  logic [11:0] last;
  // idle values at time zero
  initial begin
    cnt = 0;
    last = 12'h000;
    adc_done = 1'b0;
    adc_data = 12'hFFF;
  end
  // count down, pulse done with data, otherwise show the inverse of the last sample
  always @(posedge core_clk) begin
    adc_done <= 1'b0;
    adc_data <= ~last;
    if (adc_start) begin
      cnt <= LAT;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        adc_done <= 1'b1;
        adc_data <= sample;
        last <= sample;
      end
    end
  end
endmodule

// ===== testbench/tss_top_tb_top.sv
// self-checking bench for the touch scan sequencer
`timescale 1ns/1ps
module tss_top_tb_top;
  import tss_pkg::*;
  localparam int LAT = 20;
  logic        core_clk = 1'b0;
  logic        sys_rst, pen_down, reg_wr, reg_rd, key_scan_valid, adc_done;
  logic [7:0]  reg_addr, dac_code;
  logic [15:0] reg_wdata, reg_rdata, key_scan_bits;
  logic [11:0] adc_data;
  logic [11:0] sample = 12'hFFF;
  logic        adc_start, adc_power, conv_clk_en, x_drive_en, y_drive_en, z_drive_en;
  logic        pen_touch_irq_n, result_ready_n;
  logic [2:0]  drv, seen, first_drv;
  logic [11:0] q[$];
  int          fail_count = 0;
  int          check_count = 0;
  // design and converter model
  tss_top uut (
    .core_clk, .sys_rst, .pen_down, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .key_scan_valid, .key_scan_bits, .adc_done, .adc_data, .adc_start, .adc_power,
    .conv_clk_en, .x_drive_en, .y_drive_en, .z_drive_en, .pen_touch_irq_n,
    .result_ready_n, .dac_code
  );
  tss_adc_model #(.LAT(LAT)) u_adc (.core_clk, .adc_start, .sample, .adc_done, .adc_data);
  assign drv = {x_drive_en, y_drive_en, z_drive_en};
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  // record samples and driver use, draw the next sample
  always @(posedge core_clk) begin
    if (adc_done) begin
      q.push_back(adc_data);
      sample <= 12'($urandom);
    end
    if (seen == 3'b000) first_drv <= drv;
    seen <= seen | drv;
  end
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check(reg_rdata, e, $sformatf("register %h", a));
  endtask
  task automatic rdy(input logic e);
    cyc(2);
    check({15'h0000, result_ready_n}, {15'h0000, e}, "ready line");
  endtask
  function automatic logic [15:0] ctrl(input logic [1:0] m, input logic [3:0] f,
                                       input logic [1:0] a);
    return {m, 2'b00, f, 2'b00, a, 4'h0};
  endfunction
  function automatic logic [15:0] mean(input int first, input int n);
    int s;
    s = 0;
    for (int i = first; i < first + n; i++) s += q[i];
    return 16'(s / n);
  endfunction
  function automatic int lim(input int ovh, input int ns, input int nc);
    return ovh + ns * SETTLE0_CYC + nc * (LAT + 1 + GAP_CYC);
  endfunction
  // touch the panel, measure the scan, release on the given drivers
  task automatic touch(input logic [15:0] c, input logic [2:0] rel, output int t);
    wr(OFS_CTRL, (c[15:14] == 2'h1) ? (c & 16'hF0FF) : c);
    @(negedge core_clk);
    q.delete();
    seen = 3'b000;
    first_drv = 3'b000;
    @(posedge core_clk) pen_down <= 1'b1;
    cyc(2);
    check({15'h0000, pen_touch_irq_n}, 16'h0000, "pen irq");
    if (c[15:14] == 2'h1) wr(OFS_CTRL, c);
    for (int i = 0; i < 8 && !conv_clk_en; i++) cyc(1);
    check({15'h0000, conv_clk_en}, 16'h0001, "conversion clock");
    for (t = 0; t < 20000 && conv_clk_en; t++) begin
      @(negedge core_clk);
      if (pen_down && (drv & rel) != 3'b000) begin
        @(posedge core_clk) pen_down <= 1'b0;
        t++;
      end
    end
    @(posedge core_clk) pen_down <= 1'b0;
  endtask
  // main sequence
  initial begin
    logic [15:0] d;
    int t;
    int e;
    sys_rst = 1'b1;
    pen_down = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    key_scan_valid = 1'b0;
    key_scan_bits = 16'h0000;
    void'($urandom(32'hD1FCA9B5));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(2);
    check({7'h00, pen_touch_irq_n, dac_code}, 16'h0180, "idle pins");
    for (int a = 0; a < 5; a++) rchk(8'(a), RST_RESULT);
    rchk(OFS_DAC, RST_DAC);
    rchk(8'h05, 16'h0000);
    d = 16'($urandom) | 16'hFF00;
    wr(OFS_DAC, d);
    rchk(OFS_DAC, {8'h00, d[7:0]});
    check({8'h00, dac_code}, {8'h00, d[7:0]}, "dac code");
    wr(OFS_KEYPAD, 16'hFFFF);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 16'h8001 : 16'($urandom);
      @(posedge core_clk);
      key_scan_valid <= 1'b1;
      key_scan_bits  <= d;
      @(posedge core_clk);
      key_scan_valid <= 1'b0;
      rdy(1'b0);
      rchk(OFS_KEYPAD, d);
      rdy(1'b1);
    end
    // self-controlled coordinate scan, four-sample averages
    touch(ctrl(MODE_SELF, FN_XY, 2'h1), 3'b100, t);
    e = lim(OVH_XY_CYC, 2, 8);
    check(16'(t >= e - 8 && t <= e + 40), 16'h0001, "scan time");
    check({13'h0000, first_drv}, 16'h0002, "first driver");
    check({13'h0000, seen}, 16'h0006, "drivers used");
    check(16'(q.size()), 16'h0008, "sample count");
    rchk(OFS_Y_RESULT, mean(0, 4));
    rchk(OFS_X_RESULT, mean(4, 4));
    rdy(1'b1);
    // self-controlled scan with pressure
    touch(ctrl(MODE_SELF, FN_XYZ, 2'h0), 3'b001, t);
    e = lim(OVH_XYZ_CYC, 3, 4);
    check(16'(t >= e - 8 && t <= e + 40), 16'h0001, "scan time");
    check({13'h0000, seen}, 16'h0007, "drivers used");
    rchk(OFS_Y_RESULT, mean(0, 1));
    rchk(OFS_X_RESULT, mean(1, 1));
    rchk(OFS_Z1_RESULT, mean(2, 1));
    rchk(OFS_Z2_RESULT, mean(3, 1));
    // touch lost during the first coordinate
    touch(ctrl(MODE_SELF, FN_XY, 2'h0), 3'b010, t);
    check({13'h0000, seen}, 16'h0002, "drivers used");
    rchk(OFS_Y_RESULT, mean(0, 1));
    rdy(1'b1);
    // host-initiated single conversions
    for (int k = 0; k < 3; k++) begin
      touch(ctrl(MODE_HOST_INIT, FN_X + 4'(k), 2'h0), 3'b000, t);
      e = lim(OVH_ONE_CYC, 1, 1 + k / 2);
      check(16'(t * 100 <= e * 112), 16'h0001, "single time");
      check({13'h0000, seen}, {13'h0000, 3'(3'b100 >> k)}, "drivers used");
      rchk(8'(k), mean(0, 1));
      if (k == 2) rchk(OFS_Z2_RESULT, mean(1, 1));
    end
    // host-controlled driver and conversion steps
    for (int k = 0; k < 3; k++) begin
      q.delete();
      wr(OFS_CTRL, ctrl(MODE_HOST_CTRL, FN_NONE, 2'h0));
      @(posedge core_clk) pen_down <= 1'b1;
      wr(OFS_CTRL, ctrl(MODE_HOST_CTRL, FN_DRV_X + 4'(k), 2'h0));
      cyc(200);
      check({13'h0000, drv}, {13'h0000, 3'(3'b100 >> k)}, "drivers on");
      check(16'(q.size()), 16'h0000, "own conversion");
      check({15'h0000, adc_power}, 16'h0000, "adc power");
      wr(OFS_CTRL, ctrl(MODE_HOST_CTRL, FN_CONV_X + 4'(k), 2'h0));
      for (int i = 0; i < 3000 && q.size() < 1 + k / 2; i++) cyc(1);
      cyc(GAP_CYC + 4);
      rchk(8'(k), mean(0, 1));
      if (k == 2) rchk(OFS_Z2_RESULT, mean(1, 1));
      wr(OFS_CTRL, ctrl(MODE_HOST_CTRL, FN_STOP, 2'h0));
      cyc(2);
      check({13'h0000, drv}, 16'h0000, "drivers off");
      @(posedge core_clk) pen_down <= 1'b0;
    end
    finish_test();
  end
  // cut a hung run short
  initial begin
    #600000;
    fail_count++;
    finish_test();
  end
endmodule
